// File: rtl/rso_pkg.sv
// package: register map, reset values, codes and carriers of the relay output selector
package rso_pkg;

	// register byte offsets on the AHB-Lite bus
	localparam logic [7:0] OFS_SEL_ONE   = 8'h00;
	localparam logic [7:0] OFS_SEL_TWO   = 8'h04;
	localparam logic [7:0] OFS_SEL_THREE = 8'h08;
	localparam logic [7:0] OFS_STATE     = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h14;

	localparam int ADDR_W   = 8;
	localparam int CODE_W   = 16;
	localparam int NUM_CH   = 3;
	localparam int STATUS_W = 100;
	localparam int IDX_W    = 7;
	localparam int EVT_W    = 6;

	// selection reset values per channel
	localparam logic [CODE_W-1:0] SEL_RST_ONE   = 16'h0000;
	localparam logic [CODE_W-1:0] SEL_RST_TWO   = 16'h0001;
	localparam logic [CODE_W-1:0] SEL_RST_THREE = 16'h0002;

	// code with no function: relay stays off
	localparam logic [CODE_W-1:0] CODE_NONE = 16'h270F;

	// event bit positions in the interrupt status and mask registers
	localparam int EVT_REFUSED_RUN  = 0;
	localparam int EVT_REFUSED_CODE = 1;
	localparam int EVT_FAULT_RISE   = 2;
	localparam int EVT_RELAY_BASE   = 3;

	// bit positions of the read-only state register
	localparam int ST_RELAY_BASE = 0;
	localparam int ST_RUNNING    = 3;
	localparam int ST_FAULT      = 4;

	localparam logic [EVT_W-1:0] IRQ_MASK_RST = 6'h00;

	// contact state of one changeover relay
	typedef struct packed {
		logic energised;
		logic no_closed;
		logic nc_closed;
	} rso_relay_s;

	// accepted selection codes
	function automatic logic code_valid(input logic [CODE_W-1:0] code);
		code_valid = code inside {[16'h0000:16'h0008], [16'h000A:16'h0014],
			[16'h0019:16'h001C], [16'h001E:16'h0024], 16'h0027,
			[16'h0029:16'h002F], 16'h0040, 16'h0046,
			[16'h0055:16'h005B], [16'h005E:16'h0063], CODE_NONE};
	endfunction

endpackage

// File: rtl/rso_channel.sv
// one relay channel: picks its status signal and drives the changeover contacts
`timescale 1ns/1ns
module rso_channel (
	input  wire logic                          hclk,
	input  wire logic                          hresetn,
	input  wire logic [rso_pkg::CODE_W-1:0]    sel_code,
	input  wire logic [rso_pkg::STATUS_W-1:0]  host_status,
	input  wire logic                          option_fault,
	output rso_pkg::rso_relay_s                relay
);

	typedef struct packed {
		rso_pkg::rso_relay_s relay;
	} rso_ch_state_s;

	rso_ch_state_s state_reg;
	rso_ch_state_s state_next;

	logic picked;

	always_comb begin
		picked = 1'b0;
		// code is the host status bit index, positive logic
		if (sel_code < rso_pkg::CODE_W'(rso_pkg::STATUS_W)) begin
			picked = host_status[sel_code[rso_pkg::IDX_W-1:0]];
		end
		state_next = state_reg;
		// option fault drops the coil whatever is selected
		state_next.relay.energised = picked & ~option_fault;
		state_next.relay.no_closed = picked & ~option_fault;
		state_next.relay.nc_closed = ~(picked & ~option_fault);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= '{relay: '{energised: 1'b0, no_closed: 1'b0, nc_closed: 1'b1}};
		end else begin
			state_reg <= state_next;
		end
	end

	assign relay = state_reg.relay;

endmodule

// File: rtl/rso_top.sv
// top: AHB-Lite register slave and three status-selected changeover relays
//
// Function
// - three changeover relays with NO, NC, common
// - one selection register per relay channel
// - accept codes 0-8, 10-20, 25-28
// - also 30-36, 39, 41-47, 64, 70; reject others
// - also 85-91, 94-99 and 9999
// - selections reset to codes 0, 1, 2
// - selection writes refused while drive runs
// - option fault forces all relays off
// - codes 0 to 8 map to drive signals
// - codes 10-13, 17-19 map to signals
// - codes 14-16, 20, 25, 26 map signals
// - positive logic only, never inverted
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
module rso_top (
	input  wire logic                          hclk,
	input  wire logic                          hresetn,
	// AHB-Lite slave
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic      [31:0]                   hrdata,
	output logic                               hreadyout,
	output logic                               hresp,
	// host drive side, same clock
	input  wire logic [rso_pkg::STATUS_W-1:0]  host_status,
	input  wire logic                          drive_running,
	input  wire logic                          option_fault,
	// relay contacts and interrupt request
	output rso_pkg::rso_relay_s                relay_channel_one,
	output rso_pkg::rso_relay_s                relay_channel_two,
	output rso_pkg::rso_relay_s                relay_channel_three,
	output logic                               irq
);

	typedef struct packed {
		logic                                        dp_valid;
		logic                                        dp_write;
		logic [rso_pkg::ADDR_W-1:0]                  dp_addr;
		logic [rso_pkg::NUM_CH-1:0][rso_pkg::CODE_W-1:0] sel;
		logic [rso_pkg::EVT_W-1:0]                   irq_stat;
		logic [rso_pkg::EVT_W-1:0]                   irq_mask;
		logic                                        fault_q;
		logic [rso_pkg::NUM_CH-1:0]                  coil_q;
		logic [31:0]                                 rdata;
	} rso_state_s;

	rso_state_s state_reg;
	rso_state_s state_next;

	rso_pkg::rso_relay_s [rso_pkg::NUM_CH-1:0] relay_vec;
	logic [rso_pkg::NUM_CH-1:0]                coil_now;

	localparam rso_state_s STATE_RST = '{
		dp_valid: 1'b0,
		dp_write: 1'b0,
		dp_addr:  '0,
		sel:      {rso_pkg::SEL_RST_THREE, rso_pkg::SEL_RST_TWO, rso_pkg::SEL_RST_ONE},
		irq_stat: '0,
		irq_mask: rso_pkg::IRQ_MASK_RST,
		fault_q:  1'b0,
		coil_q:   '0,
		rdata:    '0
	};

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

	logic                          addr_take;
	logic [rso_pkg::EVT_W-1:0]     evt_set;
	logic [rso_pkg::EVT_W-1:0]     evt_clr;
	logic                          sel_hit;
	logic [1:0]                    sel_idx;
	logic [rso_pkg::CODE_W-1:0]    wr_code;
	logic                          code_ok;

	// one channel per relay, each reading its own selection
	genvar ch;
	generate
		for (ch = 0; ch < rso_pkg::NUM_CH; ch++) begin : g_ch
			rso_channel u_channel (
				.hclk         (hclk),
				.hresetn      (hresetn),
				.sel_code     (state_reg.sel[ch]),
				.host_status  (host_status),
				.option_fault (option_fault),
				.relay        (relay_vec[ch])
			);
			assign coil_now[ch] = relay_vec[ch].energised;
		end
	endgenerate

	always_comb begin
		state_next = state_reg;
		evt_set    = '0;
		evt_clr    = '0;
		sel_hit    = 1'b0;
		sel_idx    = 2'h0;
		wr_code    = hwdata[rso_pkg::CODE_W-1:0];
		// upper data bits set make the code unacceptable
		code_ok    = rso_pkg::code_valid(wr_code) && (hwdata[31:rso_pkg::CODE_W] == '0);

		unique case (state_reg.dp_addr)
			rso_pkg::OFS_SEL_ONE: begin
				sel_hit = 1'b1;
				sel_idx = 2'h0;
			end
			rso_pkg::OFS_SEL_TWO: begin
				sel_hit = 1'b1;
				sel_idx = 2'h1;
			end
			rso_pkg::OFS_SEL_THREE: begin
				sel_hit = 1'b1;
				sel_idx = 2'h2;
			end
			default: begin
				sel_hit = 1'b0;
				sel_idx = 2'h0;
			end
		endcase

		// data phase of a write
		if (state_reg.dp_valid && state_reg.dp_write) begin
			if (sel_hit) begin
				if (drive_running) begin
					evt_set[rso_pkg::EVT_REFUSED_RUN] = 1'b1;
				end else if (!code_ok) begin
					evt_set[rso_pkg::EVT_REFUSED_CODE] = 1'b1;
				end else begin
					state_next.sel[sel_idx] = wr_code;
				end
			end else if (state_reg.dp_addr == rso_pkg::OFS_IRQ_STAT) begin
				evt_clr = hwdata[rso_pkg::EVT_W-1:0];
			end else if (state_reg.dp_addr == rso_pkg::OFS_IRQ_MASK) begin
				state_next.irq_mask = hwdata[rso_pkg::EVT_W-1:0];
			end
		end

		// hardware events
		state_next.fault_q = option_fault;
		if (option_fault && !state_reg.fault_q) begin
			evt_set[rso_pkg::EVT_FAULT_RISE] = 1'b1;
		end
		state_next.coil_q = coil_now;
		evt_set[rso_pkg::EVT_RELAY_BASE +: rso_pkg::NUM_CH] = coil_now ^ state_reg.coil_q;

		// a set in the same cycle as its clear wins
		state_next.irq_stat = (state_reg.irq_stat & ~evt_clr) | evt_set;

		// address phase
		addr_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
		state_next.dp_valid = addr_take;
		state_next.dp_write = addr_take && hwrite;
		state_next.dp_addr  = addr_take ? haddr[rso_pkg::ADDR_W-1:0] : state_reg.dp_addr;

		// read data comes from the post-write values so a write is seen at once
		state_next.rdata = '0;
		if (addr_take && !hwrite) begin
			unique case (haddr[rso_pkg::ADDR_W-1:0])
				rso_pkg::OFS_SEL_ONE: begin
					state_next.rdata[rso_pkg::CODE_W-1:0] = state_next.sel[0];
				end
				rso_pkg::OFS_SEL_TWO: begin
					state_next.rdata[rso_pkg::CODE_W-1:0] = state_next.sel[1];
				end
				rso_pkg::OFS_SEL_THREE: begin
					state_next.rdata[rso_pkg::CODE_W-1:0] = state_next.sel[2];
				end
				rso_pkg::OFS_STATE: begin
					state_next.rdata[rso_pkg::ST_RELAY_BASE +: rso_pkg::NUM_CH] = coil_now;
					state_next.rdata[rso_pkg::ST_RUNNING] = drive_running;
					state_next.rdata[rso_pkg::ST_FAULT]   = option_fault;
				end
				rso_pkg::OFS_IRQ_STAT: begin
					state_next.rdata[rso_pkg::EVT_W-1:0] = state_next.irq_stat;
				end
				rso_pkg::OFS_IRQ_MASK: begin
					state_next.rdata[rso_pkg::EVT_W-1:0] = state_next.irq_mask;
				end
				default: begin
					state_next.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= STATE_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign hrdata              = state_reg.rdata;
	assign hreadyout           = 1'b1;
	assign hresp               = 1'b0;
	assign irq                 = |(state_reg.irq_stat & state_reg.irq_mask);
	assign relay_channel_one   = relay_vec[0];
	assign relay_channel_two   = relay_vec[1];
	assign relay_channel_three = relay_vec[2];

endmodule

// File: dv/rso_host_model.sv
// host drive stand-in: presents the status, run and fault levels it is told
`timescale 1ns/1ns
module rso_host_model (
	input  wire logic        hclk,
	input  wire logic [99:0] want_status,
	input  wire logic        want_run,
	input  wire logic        want_fault,
	output logic      [99:0] host_status,
	output logic             drive_running,
	output logic             option_fault
);
	always_ff @(posedge hclk) begin
		host_status   <= want_status;
		drive_running <= want_run;
		option_fault  <= want_fault;
	end
endmodule

// File: dv/rso_top_sva.sv
// checker: port relations of the relay output selector
`timescale 1ns/1ns
module rso_top_sva (
	input wire logic                         hclk,
	input wire logic                         hresetn,
	input wire logic                         hsel,
	input wire logic [31:0]                  haddr,
	input wire logic [1:0]                   htrans,
	input wire logic                         hwrite,
	input wire logic                         hready,
	input wire logic [31:0]                  hrdata,
	input wire logic                         hreadyout,
	input wire logic                         hresp,
	input wire logic                         drive_running,
	input wire logic                         option_fault,
	input wire rso_pkg::rso_relay_s          relay_channel_one,
	input wire rso_pkg::rso_relay_s          relay_channel_two,
	input wire rso_pkg::rso_relay_s          relay_channel_three
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence any_rd;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence rd_state;
		any_rd ##0 haddr[7:0] == rso_pkg::OFS_STATE;
	endsequence
	chk_fault_off: assert property (option_fault |=> !relay_channel_one.energised
		&& !relay_channel_two.energised && !relay_channel_three.energised)
		else $error("relay on during option fault");
	chk_one_contacts: assert property (relay_channel_one.no_closed
		== relay_channel_one.energised
		&& relay_channel_one.nc_closed != relay_channel_one.energised)
		else $error("relay one contacts wrong");
	chk_two_contacts: assert property (relay_channel_two.no_closed
		== relay_channel_two.energised
		&& relay_channel_two.nc_closed != relay_channel_two.energised)
		else $error("relay two contacts wrong");
	chk_three_contacts: assert property (relay_channel_three.no_closed
		== relay_channel_three.energised
		&& relay_channel_three.nc_closed != relay_channel_three.energised)
		else $error("relay three contacts wrong");
	chk_state_read: assert property (rd_state |=> hrdata[4:3]
		== $past({option_fault, drive_running}))
		else $error("state read wrong");
	chk_rdata_idle: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
		else $error("read data not cleared");
	chk_zero_wait: assert property (hreadyout)
		else $error("wait state inserted");
	chk_okay_resp: assert property (!hresp)
		else $error("error response");
endmodule
bind rso_top rso_top_sva u_rso_top_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hrdata, .hreadyout, .hresp, .drive_running, .option_fault, .relay_channel_one,
	.relay_channel_two, .relay_channel_three);

// File: dv/testbench.sv
// testbench: bus tasks and scenarios for the relay output selector
`timescale 1ns/1ns
module testbench;
	logic                hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
	logic [31:0]         haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0]          htrans = 0;
	logic [2:0]          hsize = 3'h2;
	logic [99:0]         st = 0, host_status;
	logic                run = 0, flt = 0, drive_running, option_fault;
	rso_pkg::rso_relay_s r1, r2, r3;
	int                  n_errors = 0, num_checks = 0, cyc = 0;
	logic [15:0]         good[17] = '{16'h8, 16'hA, 16'h14, 16'h19, 16'h1C, 16'h1E, 16'h24,
		16'h27, 16'h29, 16'h2F, 16'h40, 16'h46, 16'h55, 16'h5B, 16'h5E, 16'h63, 16'h270F};
	logic [15:0]         bad[9] = '{16'h9, 16'h15, 16'h18, 16'h1D, 16'h25, 16'h28, 16'h30,
		16'h41, 16'h64};
	rso_host_model u_rso_host_model (.hclk(hclk), .want_status(st), .want_run(run),
		.want_fault(flt), .host_status(host_status), .drive_running(drive_running),
		.option_fault(option_fault));
	rso_top u_rso_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .host_status(host_status),
		.drive_running(drive_running), .option_fault(option_fault), .relay_channel_one(r1),
		.relay_channel_two(r2), .relay_channel_three(r3), .irq(irq));
	always #20 hclk = ~hclk;
	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			give_verdict;
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask
	// address phase held until hready, then data phase; read data taken at its closing edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	function automatic logic [31:0] pat(input logic [2:0] on);
		pat = 32'h0;
		for (int i = 0; i < 3; i++)
			pat[3*i +: 3] = on[i] ? 3'b110 : 3'b001;
	endfunction
	task automatic rel(input logic [2:0] on);
		tick(3);
		chk("relays", pat(on), {23'h0, r1, r2, r3});
	endtask
	initial begin
		tick(3);
		hresetn <= 1'b1;
		tick(1);
		for (int i = 0; i < 3; i++) begin
			bus(0, 8'(4 * i), 0);
			chk("select reset", i, q);
			st <= 100'h1 << i;
			rel(3'b100 >> i);
		end
		st <= 0;
		rel(3'b000);
		bus(0, 8'h18, 0);
		chk("unmapped", 0, q);
		foreach (good[i]) begin
			bus(1, rso_pkg::OFS_SEL_ONE, {16'h0, good[i]});
			bus(0, rso_pkg::OFS_SEL_ONE, 0);
			chk("accepted code", {16'h0, good[i]}, q);
		end
		foreach (bad[i]) begin
			bus(1, rso_pkg::OFS_SEL_ONE, {16'h0, bad[i]});
			bus(0, rso_pkg::OFS_SEL_ONE, 0);
			chk("rejected code", 32'h270F, q);
		end
		chk("irq masked", 0, {31'h0, irq});
		bus(1, rso_pkg::OFS_IRQ_MASK, 32'h2);
		tick(1);
		chk("irq raised", 1, {31'h0, irq});
		bus(1, rso_pkg::OFS_IRQ_STAT, 32'h2);
		tick(1);
		chk("irq cleared", 0, {31'h0, irq});
		run <= 1'b1;
		tick(2);
		bus(1, rso_pkg::OFS_SEL_TWO, 32'h5);
		bus(0, rso_pkg::OFS_SEL_TWO, 0);
		chk("write while running", 1, q);
		bus(0, rso_pkg::OFS_IRQ_STAT, 0);
		chk("refused run event", 1, q & 32'h3);
		run <= 1'b0;
		tick(2);
		bus(1, rso_pkg::OFS_SEL_TWO, 32'h11);
		bus(1, rso_pkg::OFS_SEL_THREE, 32'h1A);
		st <= (100'h1 << 17) | (100'h1 << 26) | 100'h1;
		rel(3'b011);
		flt <= 1'b1;
		rel(3'b000);
		bus(0, rso_pkg::OFS_STATE, 0);
		chk("state", 32'h10, q);
		// refused run, fault rise and all three relay changes are still pending
		bus(0, rso_pkg::OFS_IRQ_STAT, 0);
		chk("event status", 32'h3D, q);
		bus(1, rso_pkg::OFS_IRQ_STAT, 32'h3F);
		bus(0, rso_pkg::OFS_IRQ_STAT, 0);
		chk("status cleared", 0, q);
		bus(0, rso_pkg::OFS_IRQ_MASK, 0);
		chk("mask readback", 32'h2, q);
		// second reset in mid-run: selections return to their defaults
		hresetn <= 1'b0;
		flt <= 1'b0;
		tick(3);
		hresetn <= 1'b1;
		tick(1);
		bus(0, rso_pkg::OFS_SEL_TWO, 0);
		chk("select two after reset", 1, q);
		bus(0, rso_pkg::OFS_IRQ_MASK, 0);
		chk("mask after reset", 0, q);
		rel(3'b100);
		give_verdict;
	end
endmodule
